// ===== src/lcd_pkg.sv
// Purpose: Shared constants and types for the command decoder
// Assumes: 25 MHz system clock, link clock sampled as data
// Notes:   Timing counts derived from times in ns
package lcd_pkg;
    localparam int        CLK_PERIOD_NS      = 40;
    localparam int        CKE_HOLD_NS        = 100;
    localparam int        CKE_HOLD_CYC       = (CKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        CPDED_LINK_EDGES   = 2;
    localparam int        READY_LINK_EDGES   = 2;
    localparam int        XP_NS              = 80;
    localparam int        XP_CYC             = (XP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        CA_W               = 10;
    localparam int        BANK_W             = 3;
    localparam int        COL_W              = 12;
    localparam int        NBANK              = 8;
    localparam int        CNT_W              = 8;
    localparam logic [CNT_W-1:0] CNT_RST     = 8'h00;
    localparam logic [7:0] BANK_RST          = 8'h00;
    // Command codes CA0..CA3 (CA0 is the leftmost bit)
    localparam logic [3:0] CODE_MRW          = 4'h0;
    localparam logic [3:0] CODE_MRR          = 4'h1;
    localparam logic [3:0] CODE_REFRESH_ONE_BANK        = 4'h2;
    localparam logic [3:0] CODE_REFRESH_ALL_BANKS        = 4'h3;
    // Activate: CA0 low, CA1 high; only bits [2:1] are compared
    localparam logic [2:0] CODE_ACT_HI       = 3'h2;
    localparam logic [2:0] CODE_WR           = 3'h4;
    localparam logic [2:0] CODE_RD           = 3'h5;
    localparam logic [3:0] CODE_PRE          = 4'hD;
    localparam logic [2:0] CODE_DPD          = 3'h6;
    localparam logic [2:0] CODE_NOP          = 3'h7;
    localparam int        AB_BIT             = 4;
    localparam int        AP_BIT             = 0;

    typedef enum logic [3:0] {
        CMD_NONE  = 4'h0,
        CMD_NOP   = 4'h1,
        CMD_MRW   = 4'h2,
        CMD_MRR   = 4'h3,
        CMD_REFRESH_ONE_BANK = 4'h4,
        CMD_REFRESH_ALL_BANKS = 4'h5,
        CMD_ACT   = 4'h6,
        CMD_WR    = 4'h7,
        CMD_RD    = 4'h8,
        CMD_PRE   = 4'h9,
        CMD_PDE   = 4'hA,
        CMD_DPDE  = 4'hB,
        CMD_SRE   = 4'hC,
        CMD_EXIT  = 4'hD,
        CMD_BAD   = 4'hE
    } lcd_cmd_t;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h0,
        ST_PDWAIT = 3'h1,
        ST_PD     = 3'h2,
        ST_DPD    = 3'h3,
        ST_XP     = 3'h4,
        ST_INIT   = 3'h5
    } lcd_state_t;
endpackage : lcd_pkg

// ===== src/lcd_cmd_if.sv
// Purpose: Carrier of one captured command between decoder stages
// Assumes: Single clock domain
// Notes:   Valid is a one-cycle pulse
`timescale 1ns/1ps
interface lcd_cmd_if;
    import lcd_pkg::*;
    logic                  valid;
    logic                  cs_n;
    logic                  cke_prev;
    logic                  cke_now;
    logic [CA_W-1:0]       ca_rise;
    logic [CA_W-1:0]       ca_fall;
    modport src (output valid, cs_n, cke_prev, cke_now, ca_rise, ca_fall);
    modport dst (input  valid, cs_n, cke_prev, cke_now, ca_rise, ca_fall);
endinterface : lcd_cmd_if

// ===== src/lcd_capture.sv
// Purpose: Synchronise link pins and capture CA on both link clock edges
// Assumes: Link clock far slower than CLK
// Notes:   Emits a command after each falling link edge
`timescale 1ns/1ps
module lcd_capture
    import lcd_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            ck_pin,
    input  wire logic            cke_pin,
    input  wire logic            cs_n_pin,
    input  wire logic [CA_W-1:0] ca_pin,
    output logic                 rise_seen,
    output logic                 cke_sync,
    lcd_cmd_if.src               cmd
);
    logic [CA_W+2:0] s1_q, s2_q, s1_d, s2_d;
    logic            ck_prev_q, ck_prev_d;
    logic            cke_last_q, cke_last_d, cke_r_q, cke_r_d, cs_r_q, cs_r_d;
    logic [CA_W-1:0] ca_r_q, ca_r_d;
    logic            v_q, v_d;
    logic [CA_W-1:0] caf_q, caf_d;
    logic            rise, fall;

    always_comb begin
        s1_d       = {ck_pin, cke_pin, cs_n_pin, ca_pin};
        s2_d       = s1_q;
        ck_prev_d  = s2_q[CA_W+2];
        rise       = s2_q[CA_W+2] & ~ck_prev_q;
        fall       = ~s2_q[CA_W+2] & ck_prev_q;
        cke_last_d = cke_last_q;
        cke_r_d    = cke_r_q;
        cs_r_d     = cs_r_q;
        ca_r_d     = ca_r_q;
        caf_d      = caf_q;
        v_d        = 1'b0;
        if (rise) begin
            cke_last_d = cke_r_q;
            cke_r_d    = s2_q[CA_W+1];
            cs_r_d     = s2_q[CA_W];
            ca_r_d     = s2_q[CA_W-1:0];
        end
        if (fall) begin
            caf_d = s2_q[CA_W-1:0];
            v_d   = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q       <= '0;
            s2_q       <= '0;
            ck_prev_q  <= 1'b0;
            cke_last_q <= 1'b1;
            cke_r_q    <= 1'b1;
            cs_r_q     <= 1'b1;
            ca_r_q     <= '0;
            caf_q      <= '0;
            v_q        <= 1'b0;
        end else begin
            s1_q       <= s1_d;
            s2_q       <= s2_d;
            ck_prev_q  <= ck_prev_d;
            cke_last_q <= cke_last_d;
            cke_r_q    <= cke_r_d;
            cs_r_q     <= cs_r_d;
            ca_r_q     <= ca_r_d;
            caf_q      <= caf_d;
            v_q        <= v_d;
        end
    end

    assign rise_seen    = rise;
    assign cke_sync     = s2_q[CA_W+1];
    assign cmd.valid    = v_q;
    assign cmd.cs_n     = cs_r_q;
    assign cmd.cke_prev = cke_last_q;
    assign cmd.cke_now  = cke_r_q;
    assign cmd.ca_rise  = ca_r_q;
    assign cmd.ca_fall  = caf_q;
endmodule : lcd_capture

// ===== src/lcd_decoder.sv
// Purpose: Command decoder and low-power state tracking
// Assumes: Controller keeps its own timing obligations
// Notes:   Link clock is sampled, not used as a clock
`timescale 1ns/1ps
module lcd_decoder
    import lcd_pkg::*;
(
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic                 CK_T,
    input  wire logic                 CKE,
    input  wire logic                 CS_N,
    input  wire logic [CA_W-1:0]      CA,
    output logic                      CMD_VALID,
    output lcd_pkg::lcd_cmd_t         CMD_CODE,
    output logic [BANK_W-1:0]         BANK,
    output logic [COL_W-1:0]          COLUMN,
    output logic                      AUTO_PRECHARGE,
    output logic [NBANK-1:0]          BANK_OPEN,
    output logic                      RX_ENABLE,
    output logic                      ARRAY_VALID,
    output logic                      READY,
    output lcd_pkg::lcd_state_t       POWER_STATE,
    output logic                      ILLEGAL
);
    import lcd_pkg::*;

    lcd_cmd_if cap ();
    logic rise_seen, cke_sync;

    lcd_capture u_cap (
        .clk      (CLK),
        .rst      (RST),
        .ck_pin   (CK_T),
        .cke_pin  (CKE),
        .cs_n_pin (CS_N),
        .ca_pin   (CA),
        .rise_seen(rise_seen),
        .cke_sync (cke_sync),
        .cmd      (cap)
    );

    function automatic lcd_cmd_t decode(input logic cs_n, input logic ckp, input logic ckn,
                                        input logic [CA_W-1:0] ca);
        logic [3:0] c;
        c = {ca[0], ca[1], ca[2], ca[3]};
        decode = CMD_BAD;
        if (ckp && ckn) begin
            if (cs_n || c[3:1] == CODE_NOP) decode = CMD_NOP;
            else if (c == CODE_MRW)   decode = CMD_MRW;
            else if (c == CODE_MRR)   decode = CMD_MRR;
            else if (c == CODE_REFRESH_ONE_BANK) decode = CMD_REFRESH_ONE_BANK;
            else if (c == CODE_REFRESH_ALL_BANKS) decode = CMD_REFRESH_ALL_BANKS;
            else if (c[3:1] == CODE_WR) decode = CMD_WR;
            else if (c[3:1] == CODE_RD) decode = CMD_RD;
            else if (c == CODE_PRE)   decode = CMD_PRE;
            else if (c[3:2] == CODE_ACT_HI[2:1]) decode = CMD_ACT;
        end else if (ckp && !ckn) begin
            if (cs_n) decode = CMD_PDE;
            else if (c[3:1] == CODE_DPD) decode = CMD_DPDE;
            else if (c[3:1] == 3'h1) decode = CMD_SRE;
        end else if (!ckp && !ckn) begin
            decode = CMD_NONE;
        end else begin
            decode = CMD_EXIT;
        end
    endfunction : decode

    lcd_state_t             st_q, st_d;
    logic [CNT_W-1:0]       cnt_q, cnt_d;
    logic                   v_q, v_d, ap_q, ap_d, rx_q, rx_d, arr_q, arr_d, rdy_q, rdy_d, ill_q, ill_d;
    lcd_cmd_t               code_q, code_d;
    logic [BANK_W-1:0]      bank_q, bank_d;
    logic [COL_W-1:0]       col_q, col_d;
    logic [NBANK-1:0]       open_q, open_d;
    lcd_cmd_t               dc;
    logic [BANK_W-1:0]      ba;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        v_d    = 1'b0;
        code_d = code_q;
        bank_d = bank_q;
        col_d  = col_q;
        ap_d   = ap_q;
        open_d = open_q;
        rx_d   = rx_q;
        arr_d  = arr_q;
        rdy_d  = rdy_q;
        ill_d  = ill_q;
        ba     = cap.ca_rise[9:7];
        dc     = decode(cap.cs_n, cap.cke_prev, cap.cke_now, cap.ca_rise);
        case (st_q)
            ST_ACTIVE, ST_INIT: begin
                if (cap.valid && rx_q) begin
                    v_d    = (dc != CMD_NOP) && (dc != CMD_NONE);
                    code_d = dc;
                    if (dc == CMD_BAD) ill_d = 1'b1;
                    if (dc == CMD_ACT) begin
                        bank_d         = ba;
                        open_d[ba]     = 1'b1;
                    end
                    if (dc == CMD_WR || dc == CMD_RD) begin
                        bank_d = ba;
                        col_d  = {cap.ca_fall[9:1], cap.ca_rise[6:5], 1'b0};
                        ap_d   = cap.ca_fall[AP_BIT];
                        if (cap.ca_fall[AP_BIT]) open_d[ba] = 1'b0;
                    end
                    if (dc == CMD_PRE) begin
                        bank_d = ba;
                        if (cap.ca_rise[AB_BIT]) open_d = BANK_RST;
                        else open_d[ba] = 1'b0;
                    end
                    if (dc == CMD_PDE || dc == CMD_SRE || dc == CMD_DPDE) begin
                        rdy_d = 1'b0;
                        cnt_d = CNT_RST;
                        st_d  = ST_PDWAIT;
                        if (dc == CMD_DPDE) begin
                            arr_d  = 1'b0;
                            open_d = BANK_RST;
                        end
                    end
                end
            end
            ST_PDWAIT: begin
                if (cap.valid) begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == CNT_W'(CPDED_LINK_EDGES - 1)) begin
                        rx_d = 1'b0;
                        st_d = (code_q == CMD_DPDE) ? ST_DPD : ST_PD;
                    end
                end
            end
            ST_PD, ST_DPD: begin
                if (cke_sync) begin
                    rx_d  = 1'b1;
                    cnt_d = CNT_RST;
                    st_d  = ST_XP;
                end
            end
            ST_XP: begin
                if (rise_seen) begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == CNT_W'(READY_LINK_EDGES + XP_CYC - 1)) begin
                        rdy_d = 1'b1;
                        st_d  = (code_q == CMD_DPDE) ? ST_INIT : ST_ACTIVE;
                    end
                end
            end
            default: st_d = ST_ACTIVE;
        endcase
        if (st_q == ST_INIT && v_d && code_d == CMD_MRW) begin
            arr_d = 1'b1;
            ill_d = 1'b0;
            st_d  = ST_ACTIVE;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q   <= ST_ACTIVE;
            cnt_q  <= CNT_RST;
            v_q    <= 1'b0;
            code_q <= CMD_NONE;
            bank_q <= '0;
            col_q  <= '0;
            ap_q   <= 1'b0;
            open_q <= BANK_RST;
            rx_q   <= 1'b1;
            arr_q  <= 1'b1;
            rdy_q  <= 1'b1;
            ill_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            v_q    <= v_d;
            code_q <= code_d;
            bank_q <= bank_d;
            col_q  <= col_d;
            ap_q   <= ap_d;
            open_q <= open_d;
            rx_q   <= rx_d;
            arr_q  <= arr_d;
            rdy_q  <= rdy_d;
            ill_q  <= ill_d;
        end
    end

    assign CMD_VALID      = v_q;
    assign CMD_CODE       = code_q;
    assign BANK           = bank_q;
    assign COLUMN         = col_q;
    assign AUTO_PRECHARGE = ap_q;
    assign BANK_OPEN      = open_q;
    assign RX_ENABLE      = rx_q;
    assign ARRAY_VALID    = arr_q;
    assign READY          = rdy_q;
    assign POWER_STATE    = st_q;
    assign ILLEGAL        = ill_q;
endmodule : lcd_decoder

// ===== verif/lcd_decoder_assertions.sv
// Purpose: Concurrent checks on decoder outputs
// Assumes: One CLK domain, RST async active high
// Notes:   Bound to lcd_decoder
`timescale 1ns/1ps
module lcd_decoder_assertions
    import lcd_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic                CKE,
    input  wire logic                CMD_VALID,
    input  wire lcd_pkg::lcd_cmd_t   CMD_CODE,
    input  wire logic [COL_W-1:0]    COLUMN,
    input  wire logic                RX_ENABLE,
    input  wire logic                ARRAY_VALID,
    input  wire logic                READY,
    input  wire lcd_pkg::lcd_state_t POWER_STATE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Asleep with CKE high for three cycles
    sequence s_asleep_wake;
        ((POWER_STATE inside {ST_PD, ST_DPD}) && CKE) [*3];
    endsequence
    a_valid_pulse: assert property (CMD_VALID |=> !CMD_VALID)
        else $error("command valid longer than one cycle");
    a_valid_not_idle: assert property (CMD_VALID |-> !(CMD_CODE inside {CMD_NONE, CMD_NOP}))
        else $error("idle command reported as valid");
    a_col_bit_zero: assert property (COLUMN[0] == 1'b0)
        else $error("column bit zero set");
    a_rx_off_state: assert property (!RX_ENABLE |-> POWER_STATE inside {ST_PD, ST_DPD})
        else $error("receivers off outside power-down");
    a_quiet_rx_off: assert property (!RX_ENABLE |-> !CMD_VALID)
        else $error("command decoded with receivers off");
    a_dpd_contents: assert property (POWER_STATE == ST_DPD |-> !ARRAY_VALID)
        else $error("array valid in deep power-down");
    a_sleep_not_ready: assert property (POWER_STATE inside {ST_PDWAIT, ST_PD, ST_DPD} |-> !READY)
        else $error("ready while in low power");
    a_wake_on_cke: assert property (s_asleep_wake |-> ##[0:3] RX_ENABLE)
        else $error("no wake on clock enable high");
    a_ready_after_xp: assert property ($rose(READY) |-> $past(POWER_STATE) == ST_XP)
        else $error("ready rose outside exit latency");
endmodule : lcd_decoder_assertions

bind lcd_decoder lcd_decoder_assertions u_chk (.CLK(CLK), .RST(RST), .CKE(CKE), .CMD_VALID(CMD_VALID),
    .CMD_CODE(CMD_CODE), .COLUMN(COLUMN), .RX_ENABLE(RX_ENABLE), .ARRAY_VALID(ARRAY_VALID),
    .READY(READY), .POWER_STATE(POWER_STATE));

// ===== verif/lcd_host_model.sv
// Purpose: Memory controller model driving the link pins
// Assumes: Frame 320 ns, eight CLK cycles, link clock high for four of them
// Notes:   Link clock rests low between frames
`timescale 1ns/1ps
module lcd_host_model
    import lcd_pkg::*;
(
    input  wire logic            clk,
    output logic                 ck_t,
    output logic                 cke,
    output logic                 cs_n,
    output logic [CA_W-1:0]      ca
);
    initial begin
        ck_t = 1'b0;
        cke  = 1'b1;
        cs_n = 1'b1;
        ca   = 10'h155;
    end
    // One command frame, rising half then falling half
    task frame(input logic c, input logic k, input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
        @(posedge clk);
        cs_n <= c;
        cke  <= k;
        ca   <= c ? ~ca : r;
        repeat (2) @(posedge clk);
        ck_t <= 1'b1;
        repeat (2) @(posedge clk);
        ca   <= c ? ca : f;
        repeat (2) @(posedge clk);
        ck_t <= 1'b0;
        repeat (2) @(posedge clk);
        ca   <= ~ca;
        cs_n <= 1'b1;
    endtask : frame
endmodule : lcd_host_model

// ===== verif/lcd_decoder_bench.sv
// Purpose: Self-checking bench for the command decoder
// Assumes: 25 MHz CLK, host model drives link pins
// Notes:   Prints only mismatches and verdict
`timescale 1ns/1ps
module lcd_decoder_bench;
    import lcd_pkg::*;
    logic                  clk;
    logic                  rst;
    logic                  ck_t;
    logic                  cke;
    logic                  cs_n;
    logic [CA_W-1:0]       ca;
    logic                  cmd_valid;
    lcd_cmd_t              cmd_code;
    logic [BANK_W-1:0]     bank;
    logic [COL_W-1:0]      column;
    logic [NBANK-1:0]      bopen;
    logic                  ap;
    logic                  rx_en;
    logic                  arr_ok;
    logic                  ready;
    lcd_state_t            pstate;
    logic                  illegal;
    int                    fail_count;
    int                    total_checks;
    int                    vcount = 0;
    int                    n;
    localparam logic [CA_W-1:0] cmd_ca [7] = '{10'h000, 10'h008, 10'h004, 10'h00C, 10'h001, 10'h005, 10'h00B};
    localparam lcd_cmd_t   cmd_exp [7] = '{CMD_MRW, CMD_MRR, CMD_REFRESH_ONE_BANK, CMD_REFRESH_ALL_BANKS, CMD_WR, CMD_RD, CMD_PRE};

    lcd_host_model host (.clk(clk), .ck_t(ck_t), .cke(cke), .cs_n(cs_n), .ca(ca));
    lcd_decoder dut (.CLK(clk), .RST(rst), .CK_T(ck_t), .CKE(cke), .CS_N(cs_n), .CA(ca),
        .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .BANK(bank), .COLUMN(column), .AUTO_PRECHARGE(ap),
        .BANK_OPEN(bopen), .RX_ENABLE(rx_en), .ARRAY_VALID(arr_ok), .READY(ready), .POWER_STATE(pstate),
        .ILLEGAL(illegal));

    initial clk = 1'b0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) vcount <= vcount + 1;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task send(input logic c, input logic k, input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
        host.frame(c, k, r, f);
        repeat (8) @(posedge clk);
    endtask : send

    task test_done;
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    initial begin
        rst = 1'b1;
        fail_count = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            n = vcount;
            send(1'b0, 1'b1, cmd_ca[i], 10'h000);
            check(16'(vcount - n), 16'h0001);
            check(16'(cmd_code), 16'(cmd_exp[i]));
        end
        // Write, bank 5, C1 C3 C11 set, auto precharge
        send(1'b0, 1'b1, 10'h2A1, 10'h203);
        check(16'(bank), 16'h0005);
        check(16'(column), 16'h080A);
        check(16'(ap), 16'h0001);
        send(1'b0, 1'b1, 10'h005, 10'h000);
        check(16'(ap), 16'h0000);
        check(16'(column), 16'h0000);
        // Activate banks 3 and 4, auto precharge, per-bank and all-bank precharge
        send(1'b0, 1'b1, 10'h182, 10'h000);
        check(16'(bank), 16'h0003);
        check(16'(bopen), 16'h0008);
        send(1'b0, 1'b1, 10'h202, 10'h000);
        check(16'(bopen), 16'h0018);
        send(1'b0, 1'b1, 10'h181, 10'h001);
        check(16'(bopen), 16'h0010);
        send(1'b0, 1'b1, 10'h182, 10'h000);
        send(1'b0, 1'b1, 10'h20B, 10'h000);
        check(16'(bopen), 16'h0008);
        send(1'b0, 1'b1, 10'h01B, 10'h000);
        check(16'(bopen), 16'h0000);
        // Both idle encodings
        n = vcount;
        send(1'b1, 1'b1, 10'h2A5, 10'h15A);
        send(1'b0, 1'b1, 10'h007, 10'h3FF);
        check(16'(vcount - n), 16'h0000);
        check(16'(illegal), 16'h0000);
        send(1'b0, 1'b1, 10'h003, 10'h000);
        check(16'(illegal), 16'h0001);
        // Power-down entry, two idles, exit
        send(1'b1, 1'b0, 10'h000, 10'h000);
        check(16'(pstate), 16'(ST_PDWAIT));
        check(16'(ready), 16'h0000);
        repeat (2) send(1'b1, 1'b0, 10'h000, 10'h000);
        check(16'(rx_en), 16'h0000);
        check(16'(pstate), 16'(ST_PD));
        n = vcount;
        send(1'b0, 1'b0, 10'h000, 10'h000);
        check(16'(vcount - n), 16'h0000);
        send(1'b1, 1'b1, 10'h000, 10'h000);
        check(16'(pstate), 16'(ST_XP));
        repeat (4) send(1'b1, 1'b1, 10'h000, 10'h000);
        check(16'(ready), 16'h0001);
        check(16'(pstate), 16'(ST_ACTIVE));
        // Deep power-down entry and exit
        check(16'(bopen), 16'h0000);
        send(1'b0, 1'b0, 10'h003, 10'h000);
        repeat (2) send(1'b1, 1'b0, 10'h000, 10'h000);
        check(16'(pstate), 16'(ST_DPD));
        check(16'(arr_ok), 16'h0000);
        send(1'b1, 1'b1, 10'h000, 10'h000);
        repeat (4) send(1'b1, 1'b1, 10'h000, 10'h000);
        check(16'(pstate), 16'(ST_INIT));
        send(1'b0, 1'b1, 10'h000, 10'h000);
        check(16'(arr_ok), 16'h0001);
        check(16'(illegal), 16'h0000);
        test_done();
    end
endmodule : lcd_decoder_bench
